// ### rtl/wdt_pkg.sv
// Package of register offsets, bit masks and timing constants.
package wdt_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] pwr_off    = 8'h04;
  localparam logic [7:0] eie_off    = 8'h08;
  localparam logic [7:0] flash_off  = 8'h0c;
  localparam logic [7:0] stat_off   = 8'h10;
  localparam logic [7:0] mask_off   = 8'h14;
  localparam logic [7:0] remain_off = 8'h18;
  // Control register bit positions and count field width.
  localparam int en_bit      = 7;
  localparam int dis_bit     = 6;
  localparam int rst_bit     = 5;
  localparam int cnt_w       = 5;
  // Power management bit position, mask 0x04.
  localparam int pwr_on_bit  = 2;
  // Extended interrupt enable bit position, mask 0x10.
  localparam int eie_wdt_bit = 4;
  // Flash configuration word reset-enable bit position, mask 0x08.
  localparam int rst_en_bit  = 3;
  localparam logic [7:0] flash_reset_val = 8'hff;
  // Interrupt vector of the watchdog expiry.
  localparam logic [15:0] wdt_vector = 16'h0063;
  // One count step of the interval: 200 ms over a count of 0x0e.
  localparam int step_us     = 14286;
  localparam int clk_mhz     = 100;
  localparam int step_cycles = step_us * clk_mhz;
  // Status bits: expiry and restart.
  localparam int st_expire   = 0;
  localparam int st_restart  = 1;
  localparam int st_w        = 2;
  // Length of the reset request pulse in cycles.
  localparam int reset_pulse = 16;
endpackage

// ### rtl/wdt_cmd_if.sv
// Interface carrying decoded command sequences to the countdown core.
interface wdt_cmd_if;
  logic       start;
  logic       stop;
  logic       restart;
  logic [4:0] count;
  logic       running;
  logic       expire;
  modport ctl  (output start, output stop, output restart, output count,
                input running, input expire);
  modport core (input start, input stop, input restart, input count,
                output running, output expire);
endinterface

// ### rtl/wdt_countdown.sv
// Watchdog countdown core with prescaled interval steps.
module wdt_countdown #(
  parameter int unsigned STEP_CYCLES = wdt_pkg::step_cycles
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic power_on,
  wdt_cmd_if.core   cmd
);
  logic [31:0] pre_q;
  logic [5:0]  left_q;
  logic        run_q;
  logic        tick;

  assign tick        = run_q && power_on && pre_q == STEP_CYCLES - 1;
  assign cmd.running = run_q;
  assign cmd.expire  = tick && left_q == 6'h01;

  // Prescaler producing one step enable per interval unit.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_q <= 32'h0;
    else if (!run_q || !power_on || cmd.restart || tick)
      pre_q <= 32'h0;
    else
      pre_q <= pre_q + 32'h1;
  end

  // Run state and steps left; restart reloads the count field.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_q  <= 1'b0;
      left_q <= 6'h0;
    end
    else if (cmd.stop)
      run_q <= 1'b0;
    else if (cmd.start || (run_q && cmd.restart))
    begin
      run_q  <= 1'b1;
      left_q <= {1'b0, cmd.count} + 6'h01;
    end
    else if (tick)
    begin
      if (left_q == 6'h01)
        left_q <= {1'b0, cmd.count} + 6'h01;
      else
        left_q <= left_q - 6'h01;
    end
  end

  // Powered off: no expiry, and the steps left do not move on their own.
  AST_NO_RUN_OFF: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !power_on |-> !cmd.expire)
    else $error("expiry while off");
  AST_OFF_HOLD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !power_on && !cmd.start && !cmd.restart |=> $stable(left_q))
    else $error("count moved while off");
endmodule

// ### rtl/wdt_top.sv
// Watchdog timer top: AHB-Lite registers, command sequences, expiry.
// Function
// - Count field sets the expiry interval
// - Enable one-then-zero starts the countdown when powered on
// - Restart one-then-zero restarts running countdown
// - Disable one-then-zero stops and clears enable
// - Expiry interrupt on wdt_irq only with enable bit set
// - Reset enabled: expiry resets, no interrupt
// - Low five control bits form count
// - Flash reset-enable bit defaults to one
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
module wdt_top #(
  parameter int unsigned STEP_CYCLES = wdt_pkg::step_cycles
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        prog_mode,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  output logic             wdt_irq,
  output logic [15:0]      wdt_irq_vector,
  output logic             cpu_reset_req
);
  wdt_cmd_if cmd ();

  logic       wr_q, rd_q;
  logic [7:0] addr_q;
  logic [7:0] ctrl_q, pwr_q, eie_q, flash_q;
  logic [wdt_pkg::st_w-1:0] stat_q, mask_q, ev;
  logic       en_q;
  logic [4:0] rst_cnt_q;
  logic       wr_ctrl, rd_stat, expire_irq, expire_rst;
  logic       prog_s1_q, prog_s2_q;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_ctrl   = wr_q && addr_q == wdt_pkg::ctrl_off;
  assign rd_stat   = rd_q && addr_q == wdt_pkg::stat_off;

  // Address phase capture for single word transfers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 8'h0;
    end
    else if (hready)
    begin
      wr_q   <= hsel && htrans[1] && hwrite;
      rd_q   <= hsel && htrans[1] && !hwrite;
      addr_q <= haddr;
    end
  end

  // Programming mode pin synchroniser.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prog_s1_q <= 1'b0;
      prog_s2_q <= 1'b0;
    end
    else
    begin
      prog_s1_q <= prog_mode;
      prog_s2_q <= prog_s1_q;
    end
  end

  // Writable registers; flash word only changes in programming mode.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q  <= 8'h0;
      pwr_q   <= 8'h0;
      eie_q   <= 8'h0;
      mask_q  <= '0;
      flash_q <= wdt_pkg::flash_reset_val;
    end
    else if (wr_q)
    begin
      unique case (addr_q)
        wdt_pkg::ctrl_off: ctrl_q <= hwdata[7:0];
        wdt_pkg::pwr_off:  pwr_q  <= hwdata[7:0];
        wdt_pkg::eie_off:  eie_q  <= hwdata[7:0];
        wdt_pkg::mask_off: mask_q <= hwdata[wdt_pkg::st_w-1:0];
        wdt_pkg::flash_off:
          if (prog_s2_q)
            flash_q <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // One-then-zero sequences: a bit written low while it stood high.
  always_comb
  begin
    cmd.start   = wr_ctrl && ctrl_q[wdt_pkg::en_bit]
                  && !hwdata[wdt_pkg::en_bit] && pwr_q[wdt_pkg::pwr_on_bit];
    cmd.stop    = wr_ctrl && ctrl_q[wdt_pkg::dis_bit]
                  && !hwdata[wdt_pkg::dis_bit];
    cmd.restart = wr_ctrl && ctrl_q[wdt_pkg::rst_bit]
                  && !hwdata[wdt_pkg::rst_bit] && en_q;
    cmd.count   = ctrl_q[wdt_pkg::cnt_w-1:0];
  end

  // Enabled state: set by the enable sequence, cleared by disable.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      en_q <= 1'b0;
    else if (cmd.stop)
      en_q <= 1'b0;
    else if (cmd.start)
      en_q <= 1'b1;
  end

  wdt_countdown #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_count (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .power_on (pwr_q[wdt_pkg::pwr_on_bit]),
    .cmd      (cmd)
  );

  // Expiry goes to reset when enabled in flash, otherwise interrupt.
  assign expire_rst = cmd.expire && flash_q[wdt_pkg::rst_en_bit];
  assign expire_irq = cmd.expire && !flash_q[wdt_pkg::rst_en_bit];
  assign ev[wdt_pkg::st_expire]  = expire_irq;
  assign ev[wdt_pkg::st_restart] = cmd.restart;

  // Sticky status; a read clears, a new event in that cycle wins.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat_q <= '0;
    else
      stat_q <= (rd_stat ? '0 : stat_q) | ev;
  end

  // Reset request pulse stretcher.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rst_cnt_q <= 5'h0;
    else if (expire_rst)
      rst_cnt_q <= 5'(wdt_pkg::reset_pulse);
    else if (rst_cnt_q != 5'h0)
      rst_cnt_q <= rst_cnt_q - 5'h01;
  end

  assign cpu_reset_req  = rst_cnt_q != 5'h0;
  assign irq            = |(stat_q & mask_q);
  assign wdt_irq        = stat_q[wdt_pkg::st_expire]
                          && eie_q[wdt_pkg::eie_wdt_bit];
  assign wdt_irq_vector = wdt_pkg::wdt_vector;

  // Read data, decoded combinationally in the data phase from the registered address.
  always_comb
  begin
    hrdata = 32'h0;
    if (rd_q)
    begin
      unique case (addr_q)
        wdt_pkg::ctrl_off:   hrdata = {24'h0, ctrl_q};
        wdt_pkg::pwr_off:    hrdata = {24'h0, pwr_q};
        wdt_pkg::eie_off:    hrdata = {24'h0, eie_q};
        wdt_pkg::flash_off:  hrdata = {24'h0, flash_q};
        wdt_pkg::stat_off:   hrdata = {30'h0, stat_q};
        wdt_pkg::mask_off:   hrdata = {30'h0, mask_q};
        wdt_pkg::remain_off: hrdata = {30'h0, cmd.running, en_q};
        default:             hrdata = 32'h0;
      endcase
    end
  end

  // Reset mode expiry: reset request, no expiry flag.
  AST_RESET_NO_IRQ: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (cmd.expire && flash_q[wdt_pkg::rst_en_bit])
      |=> cpu_reset_req && !stat_q[wdt_pkg::st_expire])
    else $error("reset expiry raised irq");
  AST_IRQ_GATE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wdt_irq |-> eie_q[wdt_pkg::eie_wdt_bit])
    else $error("irq without enable");
  // An enabled interrupt mode expiry must reach the interrupt line.
  AST_IRQ_DELIVER: assert property (
    @(posedge hclk) disable iff (!hresetn)
    expire_irq && eie_q[wdt_pkg::eie_wdt_bit]
      && !(wr_q && addr_q == wdt_pkg::eie_off) |=> wdt_irq)
    else $error("expiry interrupt not raised");
  AST_START: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd.start && !cmd.stop |=> cmd.running && en_q)
    else $error("enable sequence did not start");
  AST_STOP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd.stop |=> !cmd.running && !en_q)
    else $error("disable did not stop");
  AST_RESTART: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd.restart && !cmd.stop |=> !cmd.expire)
    else $error("expiry right after restart");
  AST_IRQ_EXPIRE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    expire_irq |=> stat_q[wdt_pkg::st_expire])
    else $error("expiry not flagged");
  AST_FLASH_LOCK: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !prog_s2_q |=> $stable(flash_q))
    else $error("flash word changed outside programming");
endmodule

// ### verif/watchdog_timer_reset_irq_bench.sv
// Self-checking bench for the watchdog: bus tasks and command sequences.
module watchdog_timer_reset_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        prog_mode;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        wdt_irq;
  logic [15:0] wdt_irq_vector;
  logic        cpu_reset_req;
  int          failures;
  int          checks_done;
  int          n;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  wdt_top #(.STEP_CYCLES(4)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .prog_mode(prog_mode), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .wdt_irq(wdt_irq),
    .wdt_irq_vector(wdt_irq_vector), .cpu_reset_req(cpu_reset_req));

  // Free-running 100 MHz clock.
  always #5 hclk = ~hclk;

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Waits for an edge with ready high, bounded.
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        failures++;
        end_of_test;
      end
      @(posedge hclk);
    end
  endtask

  // One single AHB-Lite transfer of a word.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h00000000, r);
    chk(nm, r, e);
  endtask

  // Writes a command bit as one then zero, keeping the count field.
  task automatic cmd(input logic [7:0] b, input logic [4:0] c);
    wr(wdt_pkg::ctrl_off, {24'h000000, b | {3'b000, c}});
    wr(wdt_pkg::ctrl_off, {27'h0000000, c});
  endtask

  // Full set-up: power on, interrupt enable, interval, enable sequence.
  task automatic setup(input logic [4:0] c);
    wr(wdt_pkg::pwr_off, 32'h00000004);
    wr(wdt_pkg::eie_off, 32'h00000010);
    wr(wdt_pkg::ctrl_off, {27'h0000000, c});
    cmd(8'h80, c);
  endtask

  // Counts edges until the chosen output is high, bounded.
  task automatic wait_hi(input bit rst, output int k);
    k = 0;
    while ((rst ? cpu_reset_req : wdt_irq) !== 1'b1)
    begin
      @(posedge hclk);
      k++;
      if (k > 200)
      begin
        failures++;
        end_of_test;
      end
    end
  endtask

  // Main sequence of tests.
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    prog_mode = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("flash", wdt_pkg::flash_off, 32'h000000ff);
    rchk("status", wdt_pkg::stat_off, 32'h00000000);
    wr(8'h1c, 32'h000000ff);
    rchk("unmapped", 8'h1c, 32'h00000000);
    chk("vector", {16'h0000, wdt_irq_vector}, 32'h00000063);
    chk("ready", {31'h0, hreadyout}, 32'h00000001);
    chk("response", {31'h0, hresp}, 32'h00000000);
    $display("test reset done");
    cmd(8'h80, 5'h0e);
    rchk("state unpowered", wdt_pkg::remain_off, 32'h00000000);
    $display("test power done");
    setup(5'h0e);
    rchk("state running", wdt_pkg::remain_off, 32'h00000003);
    wait_hi(1'b1, n);
    chk("interval", {31'h0, n >= 50 && n <= 70}, 32'h00000001);
    chk("irq in reset mode", {31'h0, wdt_irq}, 32'h00000000);
    n = 0;
    while (cpu_reset_req === 1'b1 && n < 40)
    begin
      @(posedge hclk);
      n++;
    end
    chk("reset pulse", n, 32'h00000010);
    cmd(8'h40, 5'h0e);
    rchk("state disabled", wdt_pkg::remain_off, 32'h00000000);
    $display("test reset mode done");
    wr(wdt_pkg::flash_off, 32'h000000f7);
    rchk("flash locked", wdt_pkg::flash_off, 32'h000000ff);
    prog_mode <= 1'b1;
    repeat (4) @(posedge hclk);
    wr(wdt_pkg::flash_off, 32'h000000f7);
    prog_mode <= 1'b0;
    repeat (4) @(posedge hclk);
    rchk("flash open", wdt_pkg::flash_off, 32'h000000f7);
    $display("test flash done");
    wr(wdt_pkg::mask_off, 32'h00000001);
    setup(5'h03);
    repeat (3)
    begin
      repeat (8) @(posedge hclk);
      cmd(8'h20, 5'h03);
    end
    rchk("status restart", wdt_pkg::stat_off, 32'h00000002);
    wait_hi(1'b0, n);
    chk("reload", {31'h0, n >= 8 && n <= 18}, 32'h00000001);
    chk("irq", {31'h0, irq}, 32'h00000001);
    chk("no reset", {31'h0, cpu_reset_req}, 32'h00000000);
    rchk("status expiry", wdt_pkg::stat_off, 32'h00000001);
    @(posedge hclk);
    chk("irq cleared", {30'h0, irq, wdt_irq}, 32'h00000000);
    wr(wdt_pkg::mask_off, 32'h00000000);
    wait_hi(1'b0, n);
    chk("irq masked", {31'h0, irq}, 32'h00000000);
    wr(wdt_pkg::eie_off, 32'h00000000);
    @(posedge hclk);
    chk("expiry gated", {31'h0, wdt_irq}, 32'h00000000);
    $display("test interrupt mode done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("state after reset", wdt_pkg::remain_off, 32'h00000000);
    rchk("flash after reset", wdt_pkg::flash_off, 32'h000000ff);
    chk("irq after reset", {31'h0, irq}, 32'h00000000);
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule
